// File: verilog/energy_meter_register_bank.sv
// Operation
// [RQ1] Address 0x01 holds the 20-bit signed current sample, written internally, read-only to the host, reset zero.
// [RQ2] Address 0x02 holds the 20-bit signed voltage sample, read-only to the host, reset zero.
// [RQ3] Addresses 0x03 and 0x04 hold 24-bit unsigned current and voltage RMS results, read-only, reset zero.
// [RQ4] Address 0x05 holds the 24-bit unsigned quick current RMS result, read-only, reset zero.
// [RQ5] Address 0x06 holds the 24-bit signed active power result, read-only, reset zero.
// [RQ6] Address 0x07 holds the 24-bit unsigned energy pulse count, read-only, reset zero.
// [RQ7] Address 0x14 is an 8-bit writable no-load power threshold resetting to 0x0b.
// [RQ8] Address 0x15 is a 16-bit writable quick RMS threshold resetting to 0xffff.
// [RQ9] Address 0x16 is a 3-bit writable quick RMS cycle count resetting to 0x1.
// [RQ10] Address 0x17 is a 2-bit writable frequency cycle count resetting to 0x3.
// [RQ11] The quick RMS update interval is chosen in whole or half line cycles, 10 to 160 ms at 50 Hz.
// [RQ12] Writing 0x5a5a5a to the software reset key at 0x1c resets the whole bank; the code leaves the link strap synchronizer untouched.
// [RQ13] Configuration writes take effect only while the unlock key at 0x1d holds 0x55, which resets to 0x00.
// [RQ14] Every transfer carries 24 data bits and narrower registers are zero padded above.
// [RQ15] Registers 0x12 to 0x1d are host read-write and internal read-only, 0x01 to 0x09 internal write, host read-only.
// [RQ16] A strap input picks the host link, low for UART and high for SPI.
// [RQ17] Host writes to measurement or undefined addresses change nothing and undefined reads return zero.
module energy_meter_register_bank (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata_r,
	output logic reg_rvalid_r,
	input wire logic meas_we,
	input wire logic [7:0] meas_addr,
	input wire logic [23:0] meas_data,
	input wire logic half_cycle_tick,
	input wire logic [23:0] quick_rms_level,
	input wire logic link_select_pin,
	output logic spi_link_selected_r,
	output logic [7:0] current_rms_offset_r,
	output logic [7:0] no_load_power_threshold_r,
	output logic [15:0] quick_rms_threshold_r,
	output logic [2:0] quick_rms_cycle_count_r,
	output logic [1:0] frequency_cycle_count_r,
	output logic [5:0] output_pin_select_r,
	output logic [9:0] user_mode_r,
	output logic [1:0] current_channel_gain_r,
	output logic writes_unlocked_r,
	output logic soft_reset_r,
	output logic quick_window_end_r
);

	logic clear;
	logic [19:0] current_sample_r;
	logic [19:0] voltage_sample_r;
	logic [23:0] current_rms_result_r;
	logic [23:0] voltage_rms_result_r;
	logic [23:0] quick_current_rms_r;
	logic [23:0] active_power_r;
	logic [23:0] energy_pulse_count_r;
	logic [15:0] line_frequency_r;
	logic [9:0] system_flags_r;
	logic [23:0] software_reset_key_r;
	logic [7:0] write_unlock_key_r;
	logic [23:0] reg_rdata_nxt;
	logic link_meta_r;
	logic link_sync_r;
	logic window_end;
	logic cfg_wr;

	// The software reset pulse acts like the reset input one cycle later, except that it leaves the link strap synchronizer untouched
	assign clear = reset | soft_reset_r; // [RQ12]

	function automatic logic is_config(input logic [7:0] a);
		return (a >= meter_regs_pkg::addr_current_rms_offset) && (a <= meter_regs_pkg::addr_write_unlock_key);
	endfunction

	// Key registers stay writable while locked, otherwise the bank could never be unlocked
	function automatic logic is_key(input logic [7:0] a);
		return (a == meter_regs_pkg::addr_software_reset_key) || (a == meter_regs_pkg::addr_write_unlock_key);
	endfunction

	assign cfg_wr = reg_wr && is_config(reg_addr) && (writes_unlocked_r || is_key(reg_addr)); // [RQ13] [RQ15]

	// Strap sampled continuously; a link switch mid-frame is the outside party's concern
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_meta_r <= 1'b0;
			link_sync_r <= 1'b0;
			spi_link_selected_r <= 1'b0;
		end else begin
			link_meta_r <= link_select_pin;
			link_sync_r <= link_meta_r;
			spi_link_selected_r <= link_sync_r; // [RQ16]
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			soft_reset_r <= 1'b0;
		end else begin
			soft_reset_r <= reg_wr && !soft_reset_r && (reg_addr == meter_regs_pkg::addr_software_reset_key)
				&& (reg_wdata == meter_regs_pkg::soft_reset_key); // [RQ12]
		end
	end

	always_ff @(posedge core_clk) begin
		if (clear) begin
			current_rms_offset_r <= meter_regs_pkg::rst_current_rms_offset;
			no_load_power_threshold_r <= meter_regs_pkg::rst_no_load_power_threshold; // [RQ7]
			quick_rms_threshold_r <= meter_regs_pkg::rst_quick_rms_threshold; // [RQ8]
			quick_rms_cycle_count_r <= meter_regs_pkg::rst_quick_rms_cycle_count; // [RQ9]
			frequency_cycle_count_r <= meter_regs_pkg::rst_frequency_cycle_count; // [RQ10]
			output_pin_select_r <= meter_regs_pkg::rst_output_pin_select;
			user_mode_r <= meter_regs_pkg::rst_user_mode;
			current_channel_gain_r <= meter_regs_pkg::rst_current_channel_gain;
			software_reset_key_r <= meter_regs_pkg::rst_software_reset_key;
			write_unlock_key_r <= meter_regs_pkg::rst_write_unlock_key; // [RQ13]
			writes_unlocked_r <= 1'b0;
		end else begin
			if (cfg_wr) begin
				unique case (reg_addr)
					meter_regs_pkg::addr_current_rms_offset: current_rms_offset_r <= reg_wdata[7:0];
					meter_regs_pkg::addr_no_load_power_threshold: no_load_power_threshold_r <= reg_wdata[7:0]; // [RQ7]
					meter_regs_pkg::addr_quick_rms_threshold: quick_rms_threshold_r <= reg_wdata[15:0]; // [RQ8]
					meter_regs_pkg::addr_quick_rms_cycle_count: quick_rms_cycle_count_r <= reg_wdata[2:0]; // [RQ9]
					meter_regs_pkg::addr_frequency_cycle_count: frequency_cycle_count_r <= reg_wdata[1:0]; // [RQ10]
					meter_regs_pkg::addr_output_pin_select: output_pin_select_r <= reg_wdata[5:0];
					meter_regs_pkg::addr_user_mode: user_mode_r <= reg_wdata[9:0];
					meter_regs_pkg::addr_current_channel_gain: current_channel_gain_r <= reg_wdata[1:0];
					meter_regs_pkg::addr_software_reset_key: software_reset_key_r <= reg_wdata;
					meter_regs_pkg::addr_write_unlock_key: begin
						write_unlock_key_r <= reg_wdata[7:0];
						writes_unlocked_r <= (reg_wdata[7:0] == meter_regs_pkg::write_unlock_value); // [RQ13]
					end
					// Holes 0x13 and 0x1b inside the range store nothing
					default: ;
				endcase
			end
		end
	end

	quick_rms_window u_quick_window (
		.core_clk(core_clk),
		.clear(clear),
		.half_cycle_tick(half_cycle_tick),
		.cycle_code(quick_rms_cycle_count_r),
		.window_end_r(window_end)
	);

	always_ff @(posedge core_clk) begin
		if (clear) begin
			quick_window_end_r <= 1'b0;
		end else begin
			quick_window_end_r <= window_end;
		end
	end

	// Only the internal port and the quick window capture load the measurement registers; the host port only clears them with the software reset key
	always_ff @(posedge core_clk) begin
		if (clear) begin
			current_sample_r <= '0; // [RQ1]
			voltage_sample_r <= '0; // [RQ2]
			current_rms_result_r <= '0; // [RQ3]
			voltage_rms_result_r <= '0;
			quick_current_rms_r <= '0; // [RQ4]
			active_power_r <= '0; // [RQ5]
			energy_pulse_count_r <= '0; // [RQ6]
			line_frequency_r <= meter_regs_pkg::rst_line_frequency;
			system_flags_r <= meter_regs_pkg::rst_system_flags;
		end else begin
			if (window_end) begin
				quick_current_rms_r <= quick_rms_level; // [RQ4] [RQ11]
			end
			if (meas_we) begin
				unique case (meas_addr)
					meter_regs_pkg::addr_current_sample: current_sample_r <= meas_data[19:0]; // [RQ1]
					meter_regs_pkg::addr_voltage_sample: voltage_sample_r <= meas_data[19:0]; // [RQ2]
					meter_regs_pkg::addr_current_rms_result: current_rms_result_r <= meas_data; // [RQ3]
					meter_regs_pkg::addr_voltage_rms_result: voltage_rms_result_r <= meas_data; // [RQ3]
					meter_regs_pkg::addr_active_power: active_power_r <= meas_data; // [RQ5]
					meter_regs_pkg::addr_energy_pulse_count: energy_pulse_count_r <= meas_data; // [RQ6]
					meter_regs_pkg::addr_line_frequency: line_frequency_r <= meas_data[15:0];
					meter_regs_pkg::addr_system_flags: system_flags_r <= meas_data[9:0];
					// Quick RMS is owned by the window capture, other codes are dropped
					default: ;
				endcase
			end
		end
	end

	// Read mux; signed samples are zero padded, not sign extended
	always_comb begin
		reg_rdata_nxt = 24'h000000; // [RQ17]
		unique case (reg_addr)
			meter_regs_pkg::addr_current_sample: reg_rdata_nxt = {4'h0, current_sample_r}; // [RQ14]
			meter_regs_pkg::addr_voltage_sample: reg_rdata_nxt = {4'h0, voltage_sample_r}; // [RQ14]
			meter_regs_pkg::addr_current_rms_result: reg_rdata_nxt = current_rms_result_r;
			meter_regs_pkg::addr_voltage_rms_result: reg_rdata_nxt = voltage_rms_result_r;
			meter_regs_pkg::addr_quick_current_rms: reg_rdata_nxt = quick_current_rms_r;
			meter_regs_pkg::addr_active_power: reg_rdata_nxt = active_power_r;
			meter_regs_pkg::addr_energy_pulse_count: reg_rdata_nxt = energy_pulse_count_r;
			meter_regs_pkg::addr_line_frequency: reg_rdata_nxt = {8'h00, line_frequency_r};
			meter_regs_pkg::addr_system_flags: reg_rdata_nxt = {14'h0000, system_flags_r};
			meter_regs_pkg::addr_current_rms_offset: reg_rdata_nxt = {16'h0000, current_rms_offset_r};
			meter_regs_pkg::addr_no_load_power_threshold: reg_rdata_nxt = {16'h0000, no_load_power_threshold_r};
			meter_regs_pkg::addr_quick_rms_threshold: reg_rdata_nxt = {8'h00, quick_rms_threshold_r};
			meter_regs_pkg::addr_quick_rms_cycle_count: reg_rdata_nxt = {21'h000000, quick_rms_cycle_count_r};
			meter_regs_pkg::addr_frequency_cycle_count: reg_rdata_nxt = {22'h000000, frequency_cycle_count_r};
			meter_regs_pkg::addr_output_pin_select: reg_rdata_nxt = {18'h00000, output_pin_select_r};
			meter_regs_pkg::addr_user_mode: reg_rdata_nxt = {14'h0000, user_mode_r};
			meter_regs_pkg::addr_current_channel_gain: reg_rdata_nxt = {22'h000000, current_channel_gain_r};
			meter_regs_pkg::addr_software_reset_key: reg_rdata_nxt = software_reset_key_r;
			meter_regs_pkg::addr_write_unlock_key: reg_rdata_nxt = {16'h0000, write_unlock_key_r};
			default: reg_rdata_nxt = 24'h000000; // [RQ17]
		endcase
	end

	// Read data holds until the next read so a slow serial shifter can take it at leisure
	always_ff @(posedge core_clk) begin
		if (clear) begin
			reg_rdata_r <= 24'h000000;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rvalid_r <= reg_rd; // [RQ15]
			if (reg_rd) begin
				reg_rdata_r <= reg_rdata_nxt; // [RQ14]
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_read_answer: assert property ( // [RQ15]
		reg_rd && !soft_reset_r |=> reg_rvalid_r ##1 (reg_rvalid_r == $past(reg_rd))
	) else $error("read answer not given one cycle after request");

	a_unmapped_zero: assert property ( // [RQ17]
		reg_rd && !soft_reset_r && (reg_addr == 8'h0a || reg_addr == 8'h13 || reg_addr > 8'h1d)
		|=> reg_rdata_r == 24'h000000
	) else $error("unmapped read returned nonzero data");

	a_sample_padding: assert property ( // [RQ14]
		reg_rd && !soft_reset_r && reg_addr == 8'h01 |=> reg_rdata_r[23:20] == 4'h0 && reg_rdata_r[19:0] == $past(current_sample_r)
	) else $error("current sample read not zero padded");

	a_locked_write: assert property ( // [RQ13]
		reg_wr && !soft_reset_r && !writes_unlocked_r && reg_addr == 8'h14 |=> $stable(no_load_power_threshold_r)
	) else $error("configuration changed while locked");

	a_unlocked_write: assert property ( // [RQ7]
		reg_wr && !soft_reset_r && writes_unlocked_r && reg_addr == 8'h14 |=> no_load_power_threshold_r == $past(reg_wdata[7:0])
	) else $error("unlocked threshold write not stored");

	a_soft_reset_key: assert property ( // [RQ12]
		reg_wr && !soft_reset_r && reg_addr == 8'h1c && reg_wdata == 24'h5a5a5a
		|=> soft_reset_r ##1 (!soft_reset_r && quick_rms_threshold_r == 16'hffff && !writes_unlocked_r
		&& energy_pulse_count_r == 24'h000000)
	) else $error("software reset key did not reset the bank");

	a_host_ro_write: assert property ( // [RQ17]
		reg_wr && !meas_we && !soft_reset_r && reg_addr == 8'h06 |=> $stable(active_power_r)
	) else $error("host write altered a measurement register");

	a_quick_capture: assert property ( // [RQ4]
		window_end && !soft_reset_r |=> quick_current_rms_r == $past(quick_rms_level) && quick_window_end_r
	) else $error("quick RMS not captured at window end");

	a_strap_sync: assert property ( // [RQ16]
		$rose(link_sync_r) |=> spi_link_selected_r
	) else $error("link select strap not passed through");

	a_rvalid_idle: assert property ( // [RQ15]
		!reg_rd |=> !reg_rvalid_r
	) else $error("read valid without a request");

	a_rdata_hold: assert property ( // [RQ14]
		!reg_rd && !soft_reset_r |=> $stable(reg_rdata_r)
	) else $error("read data moved without a read");

	a_voltage_padding: assert property ( // [RQ2]
		reg_rd && !soft_reset_r && reg_addr == 8'h02 |=> reg_rdata_r == {4'h0, $past(voltage_sample_r)}
	) else $error("voltage sample read not zero padded");

	a_creep_padding: assert property ( // [RQ7]
		reg_rd && !soft_reset_r && reg_addr == 8'h14 |=> reg_rdata_r == {16'h0000, $past(no_load_power_threshold_r)}
	) else $error("threshold read not zero padded");

	a_quick_th_padding: assert property ( // [RQ8]
		reg_rd && !soft_reset_r && reg_addr == 8'h15 |=> reg_rdata_r == {8'h00, $past(quick_rms_threshold_r)}
	) else $error("quick threshold read not zero padded");

	a_quick_cyc_padding: assert property ( // [RQ9]
		reg_rd && !soft_reset_r && reg_addr == 8'h16 |=> reg_rdata_r == {21'h0, $past(quick_rms_cycle_count_r)}
	) else $error("quick cycle count read not zero padded");

	a_frequency_cycle_count_padding: assert property ( // [RQ10]
		reg_rd && !soft_reset_r && reg_addr == 8'h17 |=> reg_rdata_r == {22'h0, $past(frequency_cycle_count_r)}
	) else $error("frequency cycle count read not zero padded");

	a_unlock_value: assert property ( // [RQ13]
		reg_wr && !soft_reset_r && reg_addr == 8'h1d |=> writes_unlocked_r == ($past(reg_wdata[7:0]) == 8'h55)
	) else $error("unlock flag does not follow the key");

	a_locked_levels: assert property ( // [RQ13]
		reg_wr && !soft_reset_r && !writes_unlocked_r && reg_addr >= 8'h12 && reg_addr <= 8'h1a
		|=> $stable(current_rms_offset_r) && $stable(quick_rms_threshold_r) && $stable(quick_rms_cycle_count_r)
	) else $error("level changed while locked");

	a_locked_modes: assert property ( // [RQ13]
		reg_wr && !soft_reset_r && !writes_unlocked_r && reg_addr >= 8'h12 && reg_addr <= 8'h1a
		|=> $stable(frequency_cycle_count_r) && $stable(output_pin_select_r) && $stable(user_mode_r)
		&& $stable(current_channel_gain_r)
	) else $error("mode changed while locked");

	a_wrong_key: assert property ( // [RQ12]
		reg_wr && reg_addr == 8'h1c && reg_wdata != 24'h5a5a5a |=> !soft_reset_r
	) else $error("software reset from a wrong key");

	a_reset_pulse: assert property ( // [RQ12]
		soft_reset_r |=> !soft_reset_r
	) else $error("software reset longer than one cycle");

	a_meas_current: assert property ( // [RQ1]
		meas_we && !soft_reset_r && meas_addr == 8'h01 |=> current_sample_r == $past(meas_data[19:0])
	) else $error("current sample not stored");

	a_meas_voltage: assert property ( // [RQ2]
		meas_we && !soft_reset_r && meas_addr == 8'h02 |=> voltage_sample_r == $past(meas_data[19:0])
	) else $error("voltage sample not stored");

	a_meas_rms: assert property ( // [RQ3]
		meas_we && !soft_reset_r && meas_addr == 8'h03 |=> current_rms_result_r == $past(meas_data)
	) else $error("current RMS not stored");

	a_meas_power: assert property ( // [RQ5]
		meas_we && !soft_reset_r && meas_addr == 8'h06 |=> active_power_r == $past(meas_data)
	) else $error("active power not stored");

	a_meas_count: assert property ( // [RQ6]
		meas_we && !soft_reset_r && meas_addr == 8'h07 |=> energy_pulse_count_r == $past(meas_data)
	) else $error("pulse count not stored");

	a_quick_not_meas: assert property ( // [RQ4]
		meas_we && !soft_reset_r && !window_end && meas_addr == 8'h05 |=> $stable(quick_current_rms_r)
	) else $error("quick RMS taken from the measurement port");

	a_host_ro_rms: assert property ( // [RQ17]
		reg_wr && !meas_we && !soft_reset_r && reg_addr == 8'h03 |=> $stable(current_rms_result_r)
	) else $error("host write altered the RMS result");

endmodule

// File: verilog/meter_regs_pkg.sv
package meter_regs_pkg;

	localparam int addr_w = 8;
	localparam int data_w = 24;

	localparam logic [7:0] addr_current_sample = 8'h01;
	localparam logic [7:0] addr_voltage_sample = 8'h02;
	localparam logic [7:0] addr_current_rms_result = 8'h03;
	localparam logic [7:0] addr_voltage_rms_result = 8'h04;
	localparam logic [7:0] addr_quick_current_rms = 8'h05;
	localparam logic [7:0] addr_active_power = 8'h06;
	localparam logic [7:0] addr_energy_pulse_count = 8'h07;
	localparam logic [7:0] addr_line_frequency = 8'h08;
	localparam logic [7:0] addr_system_flags = 8'h09;
	localparam logic [7:0] addr_current_rms_offset = 8'h12;
	localparam logic [7:0] addr_no_load_power_threshold = 8'h14;
	localparam logic [7:0] addr_quick_rms_threshold = 8'h15;
	localparam logic [7:0] addr_quick_rms_cycle_count = 8'h16;
	localparam logic [7:0] addr_frequency_cycle_count = 8'h17;
	localparam logic [7:0] addr_output_pin_select = 8'h18;
	localparam logic [7:0] addr_user_mode = 8'h19;
	localparam logic [7:0] addr_current_channel_gain = 8'h1a;
	localparam logic [7:0] addr_software_reset_key = 8'h1c;
	localparam logic [7:0] addr_write_unlock_key = 8'h1d;

	localparam int sample_w = 20;
	localparam int result_w = 24;
	localparam int line_frequency_w = 16;
	localparam int flags_w = 10;
	localparam int offset_w = 8;
	localparam int no_load_w = 8;
	localparam int quick_th_w = 16;
	localparam int quick_cyc_w = 3;
	localparam int frequency_cycle_count_w = 2;
	localparam int pin_sel_w = 6;
	localparam int mode_w = 10;
	localparam int gain_w = 2;
	localparam int unlock_w = 8;

	localparam logic [15:0] rst_line_frequency = 16'h4e20;
	localparam logic [9:0] rst_system_flags = 10'h000;
	localparam logic [7:0] rst_current_rms_offset = 8'h00;
	localparam logic [7:0] rst_no_load_power_threshold = 8'h0b;
	localparam logic [15:0] rst_quick_rms_threshold = 16'hffff;
	localparam logic [2:0] rst_quick_rms_cycle_count = 3'h1;
	localparam logic [1:0] rst_frequency_cycle_count = 2'h3;
	localparam logic [5:0] rst_output_pin_select = 6'h24;
	localparam logic [9:0] rst_user_mode = 10'h087;
	localparam logic [1:0] rst_current_channel_gain = 2'h2;
	localparam logic [23:0] rst_software_reset_key = 24'h000000;
	localparam logic [7:0] rst_write_unlock_key = 8'h00;

	localparam logic [23:0] soft_reset_key = 24'h5a5a5a;
	localparam logic [7:0] write_unlock_value = 8'h55;

	// Quick RMS window in half line cycles; 1 half cycle is 10 ms at 50 Hz, 16 is 160 ms
	localparam int quick_span_w = 5;
	localparam logic [4:0] quick_span_min = 5'h01;
	localparam logic [4:0] quick_span_max = 5'h10;

endpackage

// File: verilog/quick_rms_window.sv
module quick_rms_window (
	input wire logic core_clk,
	input wire logic clear,
	input wire logic half_cycle_tick,
	input wire logic [2:0] cycle_code,
	output logic window_end_r
);

	logic [4:0] half_count_r;
	logic [4:0] span;

	// Code 0 is half a line cycle, each step doubles, codes above 4 hold at eight cycles
	function automatic logic [4:0] span_of(input logic [2:0] code);
		logic [4:0] s;
		s = meter_regs_pkg::quick_span_max;
		if (code < 3'h5) begin
			s = meter_regs_pkg::quick_span_min << code;
		end
		return s;
	endfunction

	assign span = span_of(cycle_code);

	always_ff @(posedge core_clk) begin
		if (clear) begin
			half_count_r <= 5'h00;
			window_end_r <= 1'b0;
		end else begin
			window_end_r <= 1'b0;
			if (half_cycle_tick) begin
				// A shortened setting closes the running window at the next half cycle tick
				if (half_count_r + 5'h01 >= span) begin // [RQ11]
					half_count_r <= 5'h00;
					window_end_r <= 1'b1;
				end else begin
					half_count_r <= half_count_r + 5'h01;
				end
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (clear);

	a_window_span: assert property ( // [RQ11]
		half_cycle_tick && (half_count_r + 5'h01 >= span) |=> window_end_r && half_count_r == 5'h00
	) else $error("quick window did not close at its span");

	a_window_only_tick: assert property ( // [RQ11]
		!half_cycle_tick |=> !window_end_r
	) else $error("quick window closed without a half cycle tick");

endmodule

// File: tb/host_model.sv
module host_model (
	input wire logic core_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [23:0] reg_wdata,
	input wire logic [23:0] reg_rdata_r,
	input wire logic reg_rvalid_r
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 24'h000000;
	end

	// Released address and data show the inverse so that a stale sample cannot pass
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic v);
		@(posedge core_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata_r;
		v = reg_rvalid_r;
	endtask

	task automatic lock_key(input logic [7:0] k);
		wr(8'h1d, {16'h0000, k});
	endtask
endmodule

// File: tb/energy_meter_register_bank_tb.sv
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
	$display("unexpected %s expected %h seen %h", what, exp, got); end end

module energy_meter_register_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk, reset, reg_wr, reg_rd, reg_rvalid_r, meas_we, half_cycle_tick, link_select_pin;
	logic [7:0] reg_addr, meas_addr;
	logic [23:0] reg_wdata, reg_rdata_r, meas_data, quick_rms_level;
	logic spi_link_selected_r, writes_unlocked_r, soft_reset_r, quick_window_end_r;
	logic [7:0] current_rms_offset_r, no_load_power_threshold_r;
	logic [15:0] quick_rms_threshold_r;
	logic [2:0] quick_rms_cycle_count_r;
	logic [1:0] frequency_cycle_count_r, current_channel_gain_r;
	logic [5:0] output_pin_select_r;
	logic [9:0] user_mode_r;
	int failures = 0;
	int checks = 0;

	localparam logic [7:0] rv_a [19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1c, 8'h1d};
	localparam logic [23:0] rv_d [19] = '{0, 0, 0, 0, 0, 0, 0, 24'h4e20, 0,
		0, 24'h0b, 24'hffff, 24'h1, 24'h3, 24'h24, 24'h87, 24'h2, 0, 0};
	localparam logic [23:0] wv_d [8] = '{24'ha5, 24'h5a, 24'h1234, 24'h5, 24'h2, 24'h3f, 24'h2aa, 24'h1};

	energy_meter_register_bank i_energy_meter_register_bank (.core_clk(core_clk), .reset(reset),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .meas_we(meas_we), .meas_addr(meas_addr),
		.meas_data(meas_data), .half_cycle_tick(half_cycle_tick), .quick_rms_level(quick_rms_level),
		.link_select_pin(link_select_pin), .spi_link_selected_r(spi_link_selected_r),
		.current_rms_offset_r(current_rms_offset_r), .no_load_power_threshold_r(no_load_power_threshold_r),
		.quick_rms_threshold_r(quick_rms_threshold_r), .quick_rms_cycle_count_r(quick_rms_cycle_count_r),
		.frequency_cycle_count_r(frequency_cycle_count_r), .output_pin_select_r(output_pin_select_r),
		.user_mode_r(user_mode_r), .current_channel_gain_r(current_channel_gain_r),
		.writes_unlocked_r(writes_unlocked_r), .soft_reset_r(soft_reset_r),
		.quick_window_end_r(quick_window_end_r));

	host_model i_host_model (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
		logic [23:0] d;
		logic v;
		i_host_model.rd(a, d, v);
		`CHK("read valid", 1'b1, v)
		`CHK($sformatf("register %h", a), exp, d)
	endtask

	task automatic meas_wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge core_clk);
		#1;
		meas_we = 1'b1;
		meas_addr = a;
		meas_data = d;
		@(posedge core_clk);
		#1;
		meas_we = 1'b0;
		meas_data = ~d;
	endtask

	// One tick, then one edge: the port pulse stands for that single cycle only
	task automatic tick_chk(input logic exp);
		@(posedge core_clk);
		#1;
		half_cycle_tick = 1'b1;
		@(posedge core_clk);
		#1;
		half_cycle_tick = 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("window end", exp, quick_window_end_r)
		if (exp)
			rd_chk(8'h05, quick_rms_level);
	endtask

	task automatic t_reset_values;
		for (int i = 0; i < 19; i++)
			rd_chk(rv_a[i], rv_d[i]);
		`CHK("unlocked flag", 1'b0, writes_unlocked_r)
	endtask

	task automatic t_config_writes;
		i_host_model.wr(8'h14, 24'h33);
		rd_chk(8'h14, 24'h0b);
		i_host_model.lock_key(8'h55);
		`CHK("unlocked flag", 1'b1, writes_unlocked_r)
		for (int i = 0; i < 8; i++)
			i_host_model.wr(rv_a[i + 9], wv_d[i]);
		for (int i = 0; i < 8; i++)
			rd_chk(rv_a[i + 9], wv_d[i]);
		`CHK("threshold port", 8'h5a, no_load_power_threshold_r)
		`CHK("quick threshold port", 16'h1234, quick_rms_threshold_r)
		`CHK("quick cycles port", 3'h5, quick_rms_cycle_count_r)
		`CHK("line_frequency cycles port", 2'h2, frequency_cycle_count_r)
		`CHK("offset port", 8'ha5, current_rms_offset_r)
		`CHK("pin select port", 6'h3f, output_pin_select_r)
		`CHK("mode port", 10'h2aa, user_mode_r)
		`CHK("gain port", 2'h1, current_channel_gain_r)
		i_host_model.wr(8'h13, 24'h77);
		rd_chk(8'h13, 24'h0);
		i_host_model.lock_key(8'h54);
		i_host_model.wr(8'h14, 24'h77);
		rd_chk(8'h14, 24'h5a);
		rd_chk(8'h1d, 24'h54);
	endtask

	task automatic t_measurements;
		meas_wr(8'h01, 24'hf80001);
		meas_wr(8'h02, 24'h0abcde);
		meas_wr(8'h03, 24'h123456);
		meas_wr(8'h04, 24'h654321);
		meas_wr(8'h05, 24'h111111);
		meas_wr(8'h06, 24'h800001);
		meas_wr(8'h07, 24'h00ff00);
		meas_wr(8'h08, 24'hff1388);
		meas_wr(8'h09, 24'hfffe01);
		i_host_model.wr(8'h03, 24'hffffff);
		i_host_model.wr(8'h06, 24'h000001);
		i_host_model.wr(8'h40, 24'h000001);
		rd_chk(8'h01, 24'h080001);
		rd_chk(8'h02, 24'h0abcde);
		rd_chk(8'h03, 24'h123456);
		rd_chk(8'h04, 24'h654321);
		rd_chk(8'h05, 24'h000000);
		rd_chk(8'h06, 24'h800001);
		rd_chk(8'h07, 24'h00ff00);
		rd_chk(8'h08, 24'h001388);
		rd_chk(8'h09, 24'h000201);
		rd_chk(8'h40, 24'h000000);
		rd_chk(8'h1b, 24'h000000);
	endtask

	task automatic t_soft_reset;
		i_host_model.wr(8'h1c, 24'h5a5a5b);
		`CHK("soft reset on wrong key", 1'b0, soft_reset_r)
		i_host_model.wr(8'h1c, 24'h5a5a5a);
		`CHK("soft reset pulse", 1'b1, soft_reset_r)
		@(posedge core_clk);
		#1;
		`CHK("soft reset end", 1'b0, soft_reset_r)
		rd_chk(8'h14, 24'h0b);
		rd_chk(8'h03, 24'h0);
		rd_chk(8'h1d, 24'h0);
	endtask

	task automatic t_quick_window;
		tick_chk(1'b0);
		tick_chk(1'b1);
		i_host_model.lock_key(8'h55);
		i_host_model.wr(8'h16, 24'h0);
		quick_rms_level = 24'h00abcd;
		tick_chk(1'b1);
		i_host_model.wr(8'h16, 24'h3);
		quick_rms_level = 24'h0fedcb;
		for (int i = 0; i < 8; i++)
			tick_chk(i == 7);
		i_host_model.wr(8'h16, 24'h5);
		quick_rms_level = 24'h0a0b0c;
		for (int i = 0; i < 16; i++)
			tick_chk(i == 15);
	endtask

	initial begin
		#(5000 * 25);
		failures++;
		final_report();
	end

	initial begin
		reset = 1'b1;
		meas_we = 1'b0;
		meas_addr = 8'h00;
		meas_data = 24'h0;
		half_cycle_tick = 1'b0;
		quick_rms_level = 24'hc0ffee;
		link_select_pin = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		reset = 1'b0;
		t_reset_values();
		`CHK("link select uart", 1'b0, spi_link_selected_r)
		t_config_writes();
		t_measurements();
		t_soft_reset();
		t_quick_window();
		link_select_pin = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("link select spi", 1'b1, spi_link_selected_r)
		final_report();
	end
endmodule
